// ---- core/fmrs_pkg.sv ----
`default_nettype none
package fmrs_pkg;
  // Serial frame: hardware address, spare, register address, data; a pad heads the readback word
  localparam int FRAME_W = 24;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int HW_HI = 23;
  localparam int HW_LO = 22;
  localparam int RADDR_HI = 20;
  localparam int RADDR_LO = 16;
  localparam int DATA_HI = 15;
  localparam int DATA_LO = 0;
  localparam logic [1:0] FRAME_PAD = 2'h0;

  // Register addresses and readback codes
  localparam logic [4:0] ADDR_NOP = 5'h00;
  localparam logic [4:0] ADDR_MASK = 5'h12;
  localparam logic [4:0] ADDR_RBCTL = 5'h13;
  localparam logic [4:0] ADDR_STATUS = 5'h16;
  localparam logic [4:0] ADDR_LAST = 5'h1C;

  // Register words and reset values
  localparam int REG_W = 22;
  localparam int PIN_STATUS_BIT = 21;
  localparam logic [21:0] MASK_REG_RESET = 22'h12_0000;
  localparam logic [21:0] RBCTL_REG_RESET = 22'h13_0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [4:0] SEL_RESET = 5'h00;

  // Readback control fields
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 0;
  localparam logic [8:0] RBCTL_RSVD = 9'h000;

  // Readback modes
  localparam logic [1:0] MODE_TWO_STAGE = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_SHARED = 2'h2;
  localparam logic [1:0] MODE_ALTERNATE = 2'h3;

  // Mask bit positions
  localparam int SPI_ACCESS_MASK = 15;
  localparam int PROTECTION_SWITCH_FLAG_MASK = 14;
  localparam int INVERSE_CONVERSION_CHECK_MASK = 12;
  localparam int CLOCK_HALT_FLAG_MASK = 10;
  localparam int CONVERTER_LATCH_MONITOR_MASK = 9;
  localparam int WATCHDOG_TIMEOUT_MASK = 8;
  localparam int FRAME_SLIP_FLAG_MASK = 7;
  localparam int SERIAL_CRC_MASK = 6;
  localparam int POS_REGULATOR_SHORT_MASK = 4;
  localparam int CURRENT_OUTPUT_OPEN_MASK = 3;
  localparam int VOLTAGE_OUTPUT_SHORT_MASK = 2;
  localparam int DIE_TEMP_MASK = 0;
  // Flags that exist; bits 13, 11, 5 and 1 are reserved
  localparam logic [15:0] FLAGS_USED = 16'hD7DD;

  // Pin synchroniser reset: sclk and chip select idle high
  localparam logic [4:0] PIN_SYNC_RESET = 5'h03;

  typedef enum logic {FMRS_IDLE, FMRS_FRAME} fmrs_spi_t;
endpackage : fmrs_pkg
`default_nettype wire

// ---- core/fmrs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmrs_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta;
      logic stage2;
      logic stage3;
      // Three stages; a change counts only once stages two and three agree
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta <= RESET_VAL[i];
          stage2 <= RESET_VAL[i];
          stage3 <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end else begin
          meta <= din[i];
          stage2 <= meta;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            dout[i] <= stage3;
          end
        end
      end
    end
  endgenerate
endmodule : fmrs_sync
`default_nettype wire

// ---- core/fmrs_fault_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmrs_fault_gate #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] USED = fmrs_pkg::FLAGS_USED
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] flags,
  input wire logic [WIDTH-1:0] mask,
  output logic fault_n
);
  // Any live unmasked flag pulls the pin low; reserved bits never count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_n <= 1'b1;
    end else begin
      fault_n <= ~|(flags & ~mask & USED);
    end
  end
endmodule : fmrs_fault_gate
`default_nettype wire

// ---- core/fmrs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bit 21 of both registers reads the inverse of the fault pin level.
// - Each mask bit independently blocks only its own fault flag.
// - Mask bits 15 and 14 block SPI-access and protection-switch faults.
// - Mask bits 12 and 10 block inverse-check and clock-halt faults.
// - Mask bits 9 and 8 block latch-monitor and watchdog faults.
// - Mask bits 7 and 6 block frame-slip and serial CRC faults.
// - Mask bits 4, 3, 2 block regulator short, open current, voltage short.
// - Mask bit 0 blocks the die over-temperature fault.
// - Mask register at 0x12 resets to 0x120000, all flags unmasked.
// - Readback register at 0x13 resets to 0x130000; bits 4:0 select address.
// - Mode field bits 6:5; value 00 is two-stage readback, the default.
// - Mode 01 shifts status contents out on SDO every frame.
// - Mode 10 sets a flag after each valid write to this device.
// - Mode 10 drives status at chip-select fall only when that flag is set.
// - Mode 11 alternates status and previous instruction on SDO.
// - Select codes 0x00 to 0x1C; 0x00 is no-op, 0x16 is status.
module fmrs_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic [1:0] hw_addr,
  input wire logic [15:0] fault_flags,
  input wire logic [15:0] status_data,
  input wire logic [15:0] ext_read_data,
  output logic fault_n,
  output logic sdo,
  output logic sdo_oe,
  output logic [4:0] readback_select,
  output logic [1:0] readback_mode
);
  logic [4:0] pins_s;
  logic sclk_s;
  logic sync_n_s;
  logic sdi_s;
  logic [1:0] hw_addr_s;
  logic sclk_prev;
  logic sync_prev;
  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  fmrs_pkg::fmrs_spi_t state;
  logic [4:0] bit_cnt;
  logic [fmrs_pkg::FRAME_W-1:0] shift_in;
  logic [fmrs_pkg::FRAME_W-1:0] shift_out;
  logic [fmrs_pkg::FRAME_W-1:0] prev_frame;
  logic [15:0] mask;
  logic valid_flag;
  logic alt_phase;
  logic frame_done;
  logic addr_match;
  logic [4:0] frame_addr;
  logic pin_status;
  logic [fmrs_pkg::REG_W-1:0] mask_word;
  logic [fmrs_pkg::REG_W-1:0] rbctl_word;
  logic [fmrs_pkg::REG_W-1:0] status_word;
  logic [fmrs_pkg::REG_W-1:0] sel_word;
  logic [fmrs_pkg::FRAME_W-1:0] next_word;
  logic next_oe;

  // Pins come from the host's clock; sclk is sampled, not used as a clock
  fmrs_sync #(
    .WIDTH(5),
    .RESET_VAL(fmrs_pkg::PIN_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .din({hw_addr, sdi, sync_n, sclk}),
    .dout(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign sync_n_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign hw_addr_s = pins_s[4:3];

  // Edge finders on the filtered pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_prev <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_s;
      sync_prev <= sync_n_s;
    end
  end
  assign sclk_fall = sclk_prev & ~sclk_s;
  assign sclk_rise = ~sclk_prev & sclk_s;
  assign sync_fall = sync_prev & ~sync_n_s;
  assign sync_rise = ~sync_prev & sync_n_s;

  // Fault pin gating, registered inside the gate
  // independent mask bits
  fmrs_fault_gate #(
    .WIDTH(16),
    .USED(fmrs_pkg::FLAGS_USED)
  ) u_gate (
    .clk(clk),
    .reset(reset),
    .flags(fault_flags),
    .mask(mask),
    .fault_n(fault_n)
  );

  assign pin_status = ~fault_n;

  // Readable words; address bits are constants so writes cannot touch them
  // own address readback
  assign mask_word = {pin_status, fmrs_pkg::ADDR_MASK, mask};
  assign rbctl_word = {pin_status, fmrs_pkg::ADDR_RBCTL, fmrs_pkg::RBCTL_RSVD,
                       readback_mode, readback_select};
  assign status_word = {pin_status, fmrs_pkg::ADDR_STATUS, status_data};

  // Two-stage source; other registers live outside and answer on ext_read_data
  // select code decode
  always_comb begin
    case (readback_select)
      fmrs_pkg::ADDR_MASK: sel_word = mask_word;
      fmrs_pkg::ADDR_RBCTL: sel_word = rbctl_word;
      fmrs_pkg::ADDR_STATUS: sel_word = status_word;
      default: sel_word = {pin_status, readback_select, ext_read_data};
    endcase
  end

  // Word and drive chosen at chip-select fall
  always_comb begin
    next_word = {fmrs_pkg::FRAME_PAD, status_word};
    next_oe = 1'b1;
    case (readback_mode)
      fmrs_pkg::MODE_TWO_STAGE: next_word = {fmrs_pkg::FRAME_PAD, sel_word};
      fmrs_pkg::MODE_AUTO: next_word = {fmrs_pkg::FRAME_PAD, status_word};
      fmrs_pkg::MODE_SHARED: next_oe = valid_flag;
      fmrs_pkg::MODE_ALTERNATE: begin
        if (alt_phase) begin
          next_word = prev_frame;
        end
      end
      default: next_oe = 1'b1;
    endcase
  end

  // Frame tracking; bits are taken on falling sclk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= fmrs_pkg::FMRS_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= '0;
    end else begin
      case (state)
        fmrs_pkg::FMRS_IDLE: begin
          if (sync_fall) begin
            state <= fmrs_pkg::FMRS_FRAME;
            bit_cnt <= 5'h00;
          end
        end
        fmrs_pkg::FMRS_FRAME: begin
          if (sync_rise) begin
            state <= fmrs_pkg::FMRS_IDLE;
          end else if (sclk_fall) begin
            shift_in <= {shift_in[fmrs_pkg::FRAME_W-2:0], sdi_s};
            if (bit_cnt != 5'h1F) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        default: state <= fmrs_pkg::FMRS_IDLE;
      endcase
    end
  end

  // Only a frame of exactly the right length commits
  assign frame_done = (state == fmrs_pkg::FMRS_FRAME) && sync_rise
                      && (bit_cnt == fmrs_pkg::FRAME_BITS);
  assign addr_match = shift_in[fmrs_pkg::HW_HI:fmrs_pkg::HW_LO] == hw_addr_s;
  assign frame_addr = shift_in[fmrs_pkg::RADDR_HI:fmrs_pkg::RADDR_LO];

  // Readback shifter; first bit shows at chip-select fall, next on rising sclk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_out <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      alt_phase <= 1'b0;
    end else begin
      if (sync_fall) begin
        sdo <= next_word[fmrs_pkg::FRAME_W-1];
        shift_out <= {next_word[fmrs_pkg::FRAME_W-2:0], 1'b0};
        sdo_oe <= next_oe;
        alt_phase <= (readback_mode == fmrs_pkg::MODE_ALTERNATE) ? ~alt_phase : 1'b0;
      end else if (state == fmrs_pkg::FMRS_FRAME && sync_rise) begin
        sdo_oe <= 1'b0;
      end else if (state == fmrs_pkg::FMRS_FRAME && sclk_rise && bit_cnt != 5'h00) begin
        sdo <= shift_out[fmrs_pkg::FRAME_W-1];
        shift_out <= {shift_out[fmrs_pkg::FRAME_W-2:0], 1'b0};
      end
    end
  end

  // Register writes; reserved mask bits are stored as written
  // mask register reset and write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask <= fmrs_pkg::MASK_RESET;
    end else if (frame_done && addr_match
                 && frame_addr == fmrs_pkg::ADDR_MASK) begin
      mask <= shift_in[fmrs_pkg::DATA_HI:fmrs_pkg::DATA_LO];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readback_mode <= fmrs_pkg::MODE_RESET;
      readback_select <= fmrs_pkg::SEL_RESET;
    end else if (frame_done && addr_match
                 && frame_addr == fmrs_pkg::ADDR_RBCTL) begin
      readback_mode <= shift_in[fmrs_pkg::MODE_HI:fmrs_pkg::MODE_LO];
      readback_select <= shift_in[fmrs_pkg::SEL_HI:fmrs_pkg::SEL_LO];
    end
  end

  // Last instruction kept for the alternating mode, any device address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_frame <= '0;
    end else if (frame_done) begin
      prev_frame <= shift_in;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_flag <= 1'b0;
    end else if (frame_done) begin
      valid_flag <= addr_match;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  auto_drive_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_AUTO)
    |=> sdo_oe)
    else $error("status drive missing");
  status_bit_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_AUTO)
    |=> shift_out[fmrs_pkg::FRAME_W-2] == $past(~fault_n))
    else $error("pin status bit wrong");
  mask_indep_a: assert property ($past(fault_flags & fmrs_pkg::FLAGS_USED) != 0
    && ($past(fault_flags & ~mask & fmrs_pkg::FLAGS_USED) == 0) |-> fault_n)
    else $error("masked flag reached pin");
  spi_prot_a: assert property (($past(fault_flags[15] && !mask[15])
    || $past(fault_flags[14] && !mask[14])) |-> !fault_n)
    else $error("bit 15 or 14 flag lost");
  check_clock_a: assert property (($past(fault_flags[12] && !mask[12])
    || $past(fault_flags[10] && !mask[10])) |-> !fault_n)
    else $error("bit 12 or 10 flag lost");
  latch_wdog_a: assert property (($past(fault_flags[9] && !mask[9])
    || $past(fault_flags[8] && !mask[8])) |-> !fault_n)
    else $error("bit 9 or 8 flag lost");
  slip_crc_a: assert property (($past(fault_flags[7] && !mask[7])
    || $past(fault_flags[6] && !mask[6])) |-> !fault_n)
    else $error("bit 7 or 6 flag lost");
  output_faults_a: assert property (($past(|(fault_flags[4:2] & ~mask[4:2])))
    |-> !fault_n)
    else $error("output fault flag lost");
  die_temp_a: assert property ($past(fault_flags[0] && !mask[0]) |-> !fault_n)
    else $error("temperature flag lost");
  mask_write_a: assert property ((frame_done && addr_match
    && shift_in[20:16] == fmrs_pkg::ADDR_MASK) |=> mask == $past(shift_in[15:0]))
    else $error("mask write not taken");
  rbctl_keep_a: assert property (!frame_done |=> $stable(readback_select)
    && $stable(readback_mode))
    else $error("readback control changed without write");
  two_stage_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_TWO_STAGE
    && readback_select == fmrs_pkg::ADDR_MASK) |=> shift_out[21:17] == fmrs_pkg::ADDR_MASK)
    else $error("two-stage word wrong");
  shared_drive_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_SHARED)
    |=> sdo_oe == $past(valid_flag))
    else $error("shared mode drive wrong");
  alternate_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_ALTERNATE
    && alt_phase) |=> !alt_phase)
    else $error("alternation stuck");
  status_sel_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_TWO_STAGE
    && readback_select == fmrs_pkg::ADDR_STATUS) |=> shift_out[16:1] == $past(status_data)
    && shift_out[21:17] == fmrs_pkg::ADDR_STATUS)
    else $error("status select wrong");
  own_addr_a: assert property ((sync_fall && readback_mode == fmrs_pkg::MODE_TWO_STAGE
    && readback_select == fmrs_pkg::ADDR_RBCTL) |=> shift_out[21:17] == fmrs_pkg::ADDR_RBCTL)
    else $error("address field wrong");

  write_cover_c: cover property (frame_done && addr_match);
  shared_cover_c: cover property (sync_fall && readback_mode == fmrs_pkg::MODE_SHARED
    && valid_flag);
  alt_cover_c: cover property (sync_fall && readback_mode == fmrs_pkg::MODE_ALTERNATE
    && alt_phase);
  fault_cover_c: cover property (!fault_n ##1 fault_n);
endmodule : fmrs_top
`default_nettype wire

// ---- bench/fmrs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link: frames words in, collects the readback word
module fmrs_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  output logic done,
  output logic [23:0] rx_word,
  output logic rx_oe
);
  // Extra high-phase cycles, lets a test stretch the link clock
  int slow = 0;

  // Link idles with clock high and chip select released
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
    done = 1'b0;
    rx_word = '0;
    rx_oe = 1'b0;
  end

  // One frame of nb bits, MSB first; done pulses only for full frames
  task automatic frame(input logic [23:0] w, input int nb);
    int i;
    @(posedge clk);
    sync_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      sdi <= w[23-i];
      repeat (4 + slow) @(posedge clk);
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
      // Late in the low phase, so the bit has surely settled
      @(negedge clk);
      // Undriven line reads as the inverse, so a silent device cannot pass
      rx_word[23-i] = sdo_oe ? sdo : ~sdo;
      if (i == 0) rx_oe = sdo_oe;
      @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    sync_n <= 1'b1;
    sdi <= ~sdi; // Released line must not keep the last bit
    repeat (10) @(posedge clk);
    if (nb == 24) done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : frame
endmodule : fmrs_host
`default_nettype wire

// ---- bench/fmrs_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fmrs_top_test;
  logic clk;
  logic reset;
  logic sclk;
  logic sync_n;
  logic sdi;
  logic [1:0] hw_addr;
  logic [15:0] fault_flags;
  logic [15:0] status_data;
  logic [15:0] ext_read_data;
  logic fault_n;
  logic sdo;
  logic sdo_oe;
  logic [4:0] readback_select;
  logic [1:0] readback_mode;
  logic done;
  logic rx_oe;
  logic [23:0] rx_word;
  logic [24:0] exp_q[$];
  logic [24:0] exp_w;
  logic [4:0] sel;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 78787;
  int b;
  int md;
  // Reference copy of the register bank
  logic [15:0] m_mask = 16'h0000;
  logic [1:0] m_mode = 2'h0;
  logic [4:0] m_sel = 5'h00;
  logic m_valid = 1'b0;
  logic m_alt = 1'b0;
  logic [23:0] m_prev = 24'h00_0000;

  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fmrs_top dut (.clk(clk), .reset(reset), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
    .hw_addr(hw_addr), .fault_flags(fault_flags), .status_data(status_data),
    .ext_read_data(ext_read_data), .fault_n(fault_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .readback_select(readback_select), .readback_mode(readback_mode));

  fmrs_host host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .done(done), .rx_word(rx_word), .rx_oe(rx_oe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Expected pin state: any unmasked, existing flag
  function automatic logic flt();
    return |(fault_flags & ~m_mask & fmrs_pkg::FLAGS_USED);
  endfunction : flt

  // One frame: note the expected readback, send it, then track the bank
  task automatic xfer(input logic [1:0] hw, input logic [4:0] addr,
                      input logic [15:0] data, input int nb);
    logic [23:0] w;
    logic [23:0] e;
    logic [23:0] sw;
    logic oe;
    w = {hw, 1'b0, addr, data};
    sw = {2'b00, flt(), fmrs_pkg::ADDR_STATUS, status_data};
    oe = 1'b1;
    case (m_mode)
      fmrs_pkg::MODE_TWO_STAGE: begin
        e = {2'b00, flt(), m_sel, ext_read_data};
        if (m_sel == fmrs_pkg::ADDR_MASK) e[15:0] = m_mask;
        if (m_sel == fmrs_pkg::ADDR_RBCTL) e[15:0] = {9'h000, m_mode, m_sel};
        if (m_sel == fmrs_pkg::ADDR_STATUS) e = sw;
      end
      fmrs_pkg::MODE_SHARED: begin
        e = sw;
        oe = m_valid;
      end
      fmrs_pkg::MODE_ALTERNATE: e = m_alt ? m_prev : sw;
      default: e = sw;
    endcase
    if (nb == 24) exp_q.push_back({oe, e});
    host.frame(w, nb);
    m_alt = (m_mode == fmrs_pkg::MODE_ALTERNATE) && !m_alt;
    if (nb == 24) begin
      m_valid = (hw == hw_addr);
      m_prev = w;
      if (m_valid) begin
        if (addr == fmrs_pkg::ADDR_MASK) m_mask = data;
        if (addr == fmrs_pkg::ADDR_RBCTL) begin
          m_mode = data[6:5];
          m_sel = data[4:0];
        end
      end
    end
    if (m_mode != fmrs_pkg::MODE_ALTERNATE) m_alt = 1'b0;
    check(fault_n, !flt());
    check({readback_mode, readback_select}, {m_mode, m_sel});
  endtask : xfer

  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    if (addr == fmrs_pkg::ADDR_MASK) data = data & fmrs_pkg::FLAGS_USED;
    xfer(hw_addr, addr, data, 24);
  endtask : wr

  // Readback monitor: oldest note against each finished frame
  always @(posedge clk) begin
    if (done) begin
      if (exp_q.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        exp_w = exp_q.pop_front();
        if (exp_w[24]) check({rx_oe, rx_word}, exp_w);
        else check(rx_oe, 1'b0);
      end
    end
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    hw_addr = 2'h2;
    fault_flags = 16'h0000;
    status_data = 16'h5A3C;
    ext_read_data = 16'hC3A5;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    check({fault_n, readback_mode, readback_select}, {1'b1, 7'h00});
    // reserved and address bits ignored on write
    wr(fmrs_pkg::ADDR_RBCTL, 16'hFF93);
    xfer(hw_addr, fmrs_pkg::ADDR_NOP, 16'h0000, 24);
    wr(fmrs_pkg::ADDR_RBCTL, {11'h000, fmrs_pkg::ADDR_MASK});
    $display("test reset_readback done");
    for (b = 0; b < 16; b++) begin
      fault_flags <= 16'h0001 << b;
      @(posedge clk);
      wr(fmrs_pkg::ADDR_MASK, 16'h0000);
      wr(fmrs_pkg::ADDR_MASK, 16'h0001 << b);
      wr(fmrs_pkg::ADDR_MASK, ~(16'h0001 << b));
    end
    $display("test mask_bits done");
    hw_addr <= 2'($random(seed));
    repeat (6) @(posedge clk);
    for (b = 0; b < 20; b++) begin
      fault_flags <= 16'($random(seed));
      status_data <= 16'($random(seed));
      ext_read_data <= 16'($random(seed));
      @(posedge clk);
      sel = 5'($random(seed));
      if (sel > 5'h1C || sel inside {5'h0D, 5'h0E, 5'h19, 5'h1A, 5'h1B}) sel = 5'h13;
      wr(fmrs_pkg::ADDR_MASK, 16'($random(seed)));
      wr(fmrs_pkg::ADDR_RBCTL, {11'h000, sel});
      xfer(hw_addr, fmrs_pkg::ADDR_NOP, 16'h0000, 24);
    end
    $display("test random_readback done");
    for (md = 0; md < 4; md++) begin
      wr(fmrs_pkg::ADDR_RBCTL, {9'h000, md[1:0], fmrs_pkg::ADDR_STATUS});
      wr(fmrs_pkg::ADDR_MASK, 16'h0100);
      if (md != 3) xfer(~hw_addr, fmrs_pkg::ADDR_MASK, 16'h0004, 24);
      if (md == 2) xfer(hw_addr, fmrs_pkg::ADDR_MASK, 16'h0008, 23);
      host.slow = md;
      wr(fmrs_pkg::ADDR_MASK, 16'h0040);
      wr(fmrs_pkg::ADDR_MASK, 16'h0000);
      host.slow = 0;
    end
    $display("test modes done");
    final_report();
  end
endmodule : fmrs_top_test
`default_nettype wire
